// ===== core/ssp_pkg.sv
// constants for the spi serial port block
package ssp_pkg;
  // register addresses
  localparam logic [1:0] ADDR_BUF  = 2'h0;
  localparam logic [1:0] ADDR_CTL  = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;
  // control one fields
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OV   = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;
  // status fields
  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_BF  = 0;
  // reset values
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] BUF_RST  = 8'h00;
  // mode codes
  localparam logic [3:0] MODE_DIV4   = 4'h0;
  localparam logic [3:0] MODE_DIV16  = 4'h1;
  localparam logic [3:0] MODE_DIV64  = 4'h2;
  localparam logic [3:0] MODE_TMR    = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV    = 4'h5;
  // half bit periods in core clocks, less one
  localparam logic [5:0] HALF_DIV4  = 6'h01;
  localparam logic [5:0] HALF_DIV16 = 6'h07;
  localparam logic [5:0] HALF_DIV64 = 6'h1F;
  localparam logic [2:0] BITS_LAST  = 3'h7;
endpackage

// ===== core/ssp_spi_port.sv
// spi master and slave serial port with buffer and status registers
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// ==========================================================
// What this block does
// - bytes shift through the shift register msb first
// - after eight bits byte goes to buffer, full and irq flags set
// - received byte double buffered; next byte may start at once
// - buffer write during transfer ignored, collision flag set
// - reading buffer clears the full flag
// - shift register reachable only through the buffer
// - data launched on one edge, sampled on the opposite edge; master with cke=1 and smp=1 samples on the launch edge
// - master transfer starts when buffer is written
// - master with data out off still receives and flags bytes
// - master clock: core/4, /16, /64 or timer output /2
// - slave shifts on external clock, irq on last bit
// - select-control slave works and drives out only while select low
// - select high floats data out at once, even mid byte
// - select high or enable low resets bit counter
// - master during sleep freezes transfer, resumes after wake
// - slave shifts during sleep, irq on eight bits wakes device
// - device reset disables port and aborts transfer
// - spi modes map to polarity and edge per standard table
module ssp_spi_port (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // register port
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // system
  input  wire logic       sleep,
  input  wire logic       tmr_tick,
  output logic            irq_flag,
  output logic            wake,
  // link pins
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  input  wire logic       ss_n
);
  // ==========================================================
  // registers and state
  logic [7:0] ctl_r, stat_r, buf_r, sr_r;
  logic [2:0] cnt_r;
  logic       busy_r, irq_r, wake_r;
  logic [5:0] div_r;
  logic       sck_r, sdo_r, sdo_oe_r, sck_oe_r, lead_r, smp_d_r;
  logic [7:0] rdata_r;
  logic [2:0] sck_s_r, ss_s_r;
  logic [1:0] sdi_s_r;

  // ==========================================================
  // decode
  wire [3:0] mode     = ctl_r[3:0];
  wire       en       = ctl_r[ssp_pkg::CTL_EN];
  wire       clock_idle_polarity      = ctl_r[ssp_pkg::CTL_CKP];
  wire       cke      = stat_r[ssp_pkg::ST_CKE];
  wire       input_sample_phase      = stat_r[ssp_pkg::ST_SMP];
  wire       is_mst   = en && (mode <= ssp_pkg::MODE_TMR);
  wire       is_slv   = en && (mode == ssp_pkg::MODE_SLV_SS ||
                               mode == ssp_pkg::MODE_SLV);
  wire       use_ss   = mode == ssp_pkg::MODE_SLV_SS;
  wire       ss_hi    = ss_s_r[1];
  // select high or port disabled holds the port in reset
  wire       port_rst = !en || (is_slv && use_ss && ss_hi);
  wire       wr_buf   = wr && addr == ssp_pkg::ADDR_BUF;
  wire       rd_buf   = rd && addr == ssp_pkg::ADDR_BUF;
  wire       wr_ctl   = wr && addr == ssp_pkg::ADDR_CTL;
  wire       wr_stat  = wr && addr == ssp_pkg::ADDR_STAT;
  // slave can write any time when idle; busy once a bit moved
  wire       xfer_on  = busy_r;
  wire       write_collision_flag_set = wr_buf && xfer_on;
  wire       wr_ok    = wr_buf && !xfer_on && en;

  // master rate select
  wire [5:0] half_lim = (mode == ssp_pkg::MODE_DIV4)  ? ssp_pkg::HALF_DIV4 :
                        (mode == ssp_pkg::MODE_DIV16) ? ssp_pkg::HALF_DIV16 :
                                                        ssp_pkg::HALF_DIV64;
  wire       use_tmr  = mode == ssp_pkg::MODE_TMR;
  // sleep freezes the divider; state held in place
  wire       m_tick   = is_mst && busy_r && !sleep &&
                        (use_tmr ? tmr_tick : div_r == half_lim);

  // slave clock edges after two-flop sync
  wire       sck_rise = sck_s_r[1] && !sck_s_r[2];
  wire       sck_fall = !sck_s_r[1] && sck_s_r[2];
  // leading edge goes idle-to-active; ckp selects idle level
  wire       s_lead   = clock_idle_polarity ? sck_fall : sck_rise;
  wire       s_trail  = clock_idle_polarity ? sck_rise : sck_fall;
  // cke=1 launches on active-to-idle, so sample on leading
  wire       s_samp   = is_slv && !port_rst && (cke ? s_lead : s_trail);
  wire       s_shift  = is_slv && !port_rst && (cke ? s_trail : s_lead);

  // master: lead_r low in first half, high in second; second half ends bit
  wire       m_first  = m_tick && !lead_r;
  wire       m_second = m_tick && lead_r;
  // smp=1 moves master sample to end of bit
  // with cke=0 the end of the bit is the trailing edge, so both phases sample there
  wire       m_samp   = (cke && !input_sample_phase) ? m_first : m_second;
  // master samples even with data out unused
  wire       samp     = is_mst ? m_samp : s_samp;
  wire       done     = samp && cnt_r == ssp_pkg::BITS_LAST;
  wire       full     = stat_r[ssp_pkg::ST_BF];
  wire       ov_set   = done && is_slv && full;
  wire [7:0] rx_byte  = {sr_r[6:0], sdi_s_r[1]};

  wire [7:0] rd_mux   = (addr == ssp_pkg::ADDR_BUF)  ? buf_r :
                        (addr == ssp_pkg::ADDR_CTL)  ? ctl_r :
                        (addr == ssp_pkg::ADDR_STAT) ? stat_r : 8'h00;

  // ==========================================================
  // synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_s_r <= 3'h0;
      ss_s_r  <= 3'h7;
      sdi_s_r <= 2'h0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], sck_in};
      ss_s_r  <= {ss_s_r[1:0], ss_n};
      sdi_s_r <= {sdi_s_r[0], sdi};
    end
  end

  // ==========================================================
  // control and status registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_r  <= ssp_pkg::CTL_RST;
      stat_r <= ssp_pkg::STAT_RST;
    end else begin
      if (wr_ctl)
        ctl_r <= wdata;
      // set wins over a clearing write in the same cycle
      if (write_collision_flag_set)
        ctl_r[ssp_pkg::CTL_WRITE_COLLISION_FLAG] <= 1'b1;
      if (ov_set)
        ctl_r[ssp_pkg::CTL_OV] <= 1'b1;
      if (wr_stat)
        stat_r[7:6] <= wdata[7:6];
      if (rd_buf)
        stat_r[ssp_pkg::ST_BF] <= 1'b0;
      if (done && !ov_set)
        stat_r[ssp_pkg::ST_BF] <= 1'b1;
    end
  end

  // ==========================================================
  // buffer, shift register and bit counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf_r   <= ssp_pkg::BUF_RST;
      sr_r    <= ssp_pkg::BUF_RST;
      cnt_r   <= 3'h0;
      busy_r  <= 1'b0;
      smp_d_r <= 1'b0;
    end else if (port_rst) begin
      cnt_r  <= 3'h0;
      busy_r <= 1'b0;
      if (wr_ok) begin
        buf_r <= wdata;
        sr_r  <= wdata;
      end
    end else begin
      // write lands in both buffer and shift register
      if (wr_ok) begin
        buf_r  <= wdata;
        sr_r   <= wdata;
        busy_r <= is_mst;
      end
      if (samp) begin
        smp_d_r <= sdi_s_r[1];
        cnt_r   <= cnt_r + 3'h1;
        if (is_slv)
          busy_r <= 1'b1;
      end
      if (done) begin
        busy_r <= 1'b0;
        sr_r   <= rx_byte;
        // old byte kept on overflow
        if (!ov_set)
          buf_r <= rx_byte;
      end else if (samp && input_sample_phase) begin
        sr_r <= rx_byte;
      end else if (samp && !input_sample_phase && is_mst) begin
        sr_r <= rx_byte;
      end else if (samp && is_slv) begin
        sr_r <= rx_byte;
      end
    end
  end

  // ==========================================================
  // master clock generator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r      <= 6'h00;
      lead_r     <= 1'b0;
      sck_r      <= 1'b0;
    end else if (!is_mst || !busy_r) begin
      div_r  <= 6'h00;
      lead_r <= 1'b0;
      sck_r  <= clock_idle_polarity;
    end else if (!sleep) begin
      div_r <= (div_r == half_lim) ? 6'h00 : div_r + 6'h01;
      // timer mode: each tick is one half bit, so the bit is timer/2
      if (m_tick) begin
        lead_r <= !lead_r;
        sck_r  <= !sck_r;
      end
    end
  end

  // ==========================================================
  // pin drivers: launch on one edge, sample on the other, except master with cke=1 and smp=1 (same edge)
  wire launch_m = is_mst && (cke ? m_second : m_first);
  wire drv_ok   = is_mst || (is_slv && !(use_ss && ss_hi));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdo_r    <= 1'b0;
      sdo_oe_r <= 1'b0;
      sck_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= is_mst;
      // floats as soon as select rises
      sdo_oe_r <= drv_ok;
      // a new byte shows its msb at once
      if (wr_ok)
        sdo_r <= wdata[7];
      else if (!busy_r && !samp)
        sdo_r <= sr_r[7];
      // sample on the same edge: next bit is one place further down
      else if (s_shift || launch_m)
        sdo_r <= samp ? sr_r[6] : sr_r[7];
    end
  end

  // ==========================================================
  // read port, interrupt flag and wake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
      wake_r  <= 1'b0;
    end else begin
      rdata_r <= rd ? rd_mux : 8'h00;
      irq_r   <= done;
      wake_r  <= done && sleep && is_slv;
    end
  end

  assign rdata    = rdata_r;
  assign irq_flag = irq_r;
  assign wake     = wake_r;
  assign sck_out  = sck_r;
  assign sck_oe   = sck_oe_r;
  assign sdo      = sdo_r;
  assign sdo_oe   = sdo_oe_r;

  // ==========================================================
  // checks
  sequence byte_end_s;
    done && !ov_set;
  endsequence

  buf_full_a: assert property (@(posedge mclk) disable iff (rst)
    byte_end_s |=> stat_r[ssp_pkg::ST_BF])
    else $error("full flag not set after byte");
  irq_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    done |=> irq_flag)
    else $error("irq flag missing after byte");
  write_collision_flag_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_buf && busy_r && !done) |=>
      ctl_r[ssp_pkg::CTL_WRITE_COLLISION_FLAG] && $stable(buf_r))
    else $error("collision write not flagged or not ignored");
  bf_clear_a: assert property (@(posedge mclk) disable iff (rst)
    (rd_buf && !done) |=> !stat_r[ssp_pkg::ST_BF])
    else $error("full flag not cleared by read");
  ss_float_a: assert property (@(posedge mclk) disable iff (rst)
    (is_slv && use_ss && ss_hi) |=> !sdo_oe)
    else $error("data out driven while select high");
  cnt_reset_a: assert property (@(posedge mclk) disable iff (rst)
    port_rst |=> cnt_r == 3'h0)
    else $error("bit counter not cleared");
  ov_keep_a: assert property (@(posedge mclk) disable iff (rst)
    ov_set |=> ctl_r[ssp_pkg::CTL_OV] && $stable(buf_r))
    else $error("overflow not flagged or buffer overwritten");
  sleep_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (is_mst && sleep) |=> $stable(cnt_r) && $stable(sck_out))
    else $error("master moved during sleep");
  start_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_ok && is_mst) |=> busy_r)
    else $error("master did not start on write");

  // ==========================================================
  // helper: halves of the master clock in the current byte
  logic [4:0] half_cnt_r;
  wire        wdata_msb = wdata[7];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      half_cnt_r <= 5'h00;
    end else if (!busy_r) begin
      half_cnt_r <= 5'h00;
    end else if (m_tick) begin
      half_cnt_r <= half_cnt_r + 5'h01;
    end
  end

  sequence mst_load_s;
    wr_ok && is_mst;
  endsequence

  sequence slv_sel_off_s;
    is_slv && use_ss && ss_hi;
  endsequence

  sequence mst_idle_s;
    is_mst && !busy_r && !wr_ctl;
  endsequence

  sequence sleep_byte_s;
    done && sleep && is_slv;
  endsequence

  // a byte is sixteen halves at most, whatever the rate
  half_limit_a: assert property (@(posedge mclk) disable iff (rst)
    (is_mst && busy_r) |-> half_cnt_r < 5'h10)
    else $error("master byte ran past sixteen clock halves");

  msb_out_a: assert property (@(posedge mclk) disable iff (rst)
    mst_load_s |=> sdo == $past(wdata_msb))
    else $error("first bit out is not the msb");

  ss_no_samp_a: assert property (@(posedge mclk) disable iff (rst)
    slv_sel_off_s |-> !samp)
    else $error("slave sampled while select high");

  idle_clk_a: assert property (@(posedge mclk) disable iff (rst)
    mst_idle_s |=> sck_out == clock_idle_polarity)
    else $error("master clock not at idle level");

  wake_a: assert property (@(posedge mclk) disable iff (rst)
    sleep_byte_s |=> wake)
    else $error("no wake after slave byte in sleep");

  off_float_a: assert property (@(posedge mclk) disable iff (rst)
    !en |=> !sck_oe && !sdo_oe)
    else $error("pins driven while port disabled");

  mst_oe_a: assert property (@(posedge mclk) disable iff (rst)
    is_mst |=> sck_oe)
    else $error("master mode does not drive the clock");

  no_ov_mst_a: assert property (@(posedge mclk) disable iff (rst)
    is_mst |-> !ov_set)
    else $error("overflow raised in master mode");

  buf_load_a: assert property (@(posedge mclk) disable iff (rst)
    byte_end_s |=> buf_r == $past(rx_byte))
    else $error("received byte not moved to buffer");

  rd_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  write_collision_flag_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (ctl_r[ssp_pkg::CTL_WRITE_COLLISION_FLAG] && !wr_ctl) |=> ctl_r[ssp_pkg::CTL_WRITE_COLLISION_FLAG])
    else $error("collision flag dropped without a write");

  bf_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (full && !rd_buf) |=> stat_r[ssp_pkg::ST_BF])
    else $error("full flag dropped without a read");

  irq_once_a: assert property (@(posedge mclk) disable iff (rst)
    irq_flag |=> !irq_flag)
    else $error("irq flag longer than one cycle");
endmodule

// ===== tb/ssp_slave_model.sv
// partner spi slave device used against the port in master mode
`timescale 1ns/1ps
// ==========================================================
// slave device
module ssp_slave_model (
  // link pins
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  // bench control
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] shift_r;
  assign sdi = shift_r[7];
  // launch on falling, capture on rising; refill keeps the line toggling
  always @(negedge sck or posedge load) begin
    if (load) begin
      shift_r <= tx_byte;
    end else begin
      shift_r <= {shift_r[6:0], ~shift_r[0]};
    end
  end
  always @(posedge sck) begin
    rx_byte <= {rx_byte[6:0], sdo};
  end
endmodule

// ===== tb/ssp_spi_port_test.sv
// self-checking bench for the spi serial port
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("Error at %0t: got %h expected %h", $time, \
  got, exp); end end
// ==========================================================
// bench
module ssp_spi_port_test;
  logic       mclk, rst, wr, rd, sleep, tmr_tick, sck_in, tb_sdi, ss_n;
  logic       irq_flag, wake, sck_out, sck_oe, sdo, sdo_oe, load, sdi_m;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, rx_byte, tx_byte, rv;
  int         miscompares, total_checks, cycles, irq_cnt, wake_cnt;
  ssp_spi_port u_ssp_spi_port (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep),
    .tmr_tick(tmr_tick), .irq_flag(irq_flag), .wake(wake),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdi(sck_oe ? sdi_m : tb_sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .ss_n(ss_n));
  ssp_slave_model u_ssp_slave_model (.sck(sck_out), .sdo(sdo),
    .sdi(sdi_m), .load(load), .tx_byte(tx_byte), .rx_byte(rx_byte));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // whole run needs a few thousand cycles
  always @(posedge mclk) begin
    cycles++;
    tmr_tick <= (cycles % 4 == 0);
    if (irq_flag === 1'b1) irq_cnt++;
    if (wake === 1'b1) wake_cnt++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk); wr <= 1'b0;
  endtask
  task rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk); addr <= a; rd <= 1'b1;
    @(posedge mclk); rd <= 1'b0;
    #1 d = rdata;
  endtask
  task wait_irq(output int n);
    n = 0;
    while (irq_flag !== 1'b1 && n < 2000) begin
      @(posedge mclk); #1 n++;
    end
  endtask
  task start_byte(input logic [7:0] slv, input logic [7:0] mst);
    @(posedge mclk); tx_byte <= slv; load <= 1'b1;
    @(posedge mclk); load <= 1'b0;
    wr_reg(ssp_pkg::ADDR_BUF, mst);
  endtask
  task t_reset;
    rd_reg(ssp_pkg::ADDR_CTL, rv);
    `CHK(rv, ssp_pkg::CTL_RST)
    rd_reg(ssp_pkg::ADDR_STAT, rv);
    `CHK(rv, ssp_pkg::STAT_RST)
    rd_reg(2'h3, rv);
    `CHK(rv, 8'h00)
    `CHK(sck_oe, 1'b0)
  endtask
  task t_master;
    int n;
    wr_reg(ssp_pkg::ADDR_STAT, 8'h40);
    wr_reg(ssp_pkg::ADDR_CTL, 8'h21);
    start_byte(8'hA5, 8'h3C);
    wait_irq(n);
    `CHK(rx_byte, 8'h3C)
    rd_reg(ssp_pkg::ADDR_STAT, rv);
    `CHK(rv, 8'h41)
    rd_reg(ssp_pkg::ADDR_BUF, rv);
    `CHK(rv, 8'hA5)
    rd_reg(ssp_pkg::ADDR_STAT, rv);
    `CHK(rv, 8'h40)
  endtask
  task t_collide;
    int n;
    start_byte(8'h00, 8'h5A);
    wr_reg(ssp_pkg::ADDR_BUF, 8'hFF);
    wait_irq(n);
    `CHK(rx_byte, 8'h5A)
    rd_reg(ssp_pkg::ADDR_CTL, rv);
    `CHK(rv, 8'hA1)
    wr_reg(ssp_pkg::ADDR_CTL, 8'h21);
    rd_reg(ssp_pkg::ADDR_CTL, rv);
    `CHK(rv, 8'h21)
    rd_reg(ssp_pkg::ADDR_BUF, rv);
    `CHK(rv, 8'h00)
  endtask
  task t_rates;
    int n, e;
    // end-of-bit sampling leaves room for the input synchroniser
    wr_reg(ssp_pkg::ADDR_STAT, 8'hC0);
    for (int m = 0; m < 4; m++) begin
      e = (m == 3) ? 64 : 32 << (2 * m);
      wr_reg(ssp_pkg::ADDR_CTL, 8'h20 | m[7:0]);
      start_byte(8'h0F, 8'hF0);
      wait_irq(n);
      `CHK(n >= e - 4 && n <= e + 8, 1'b1)
      rd_reg(ssp_pkg::ADDR_BUF, rv);
      `CHK(rv, 8'h0F)
    end
  endtask
  task t_sleep;
    int n, k;
    logic s;
    wr_reg(ssp_pkg::ADDR_CTL, 8'h22);
    start_byte(8'h69, 8'h96);
    repeat (100) @(posedge mclk);
    sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    k = irq_cnt;
    s = sck_out;
    repeat (600) @(posedge mclk);
    `CHK(irq_cnt, k)
    `CHK(sck_out, s)
    sleep <= 1'b0;
    wait_irq(n);
    `CHK(rx_byte, 8'h96)
    rd_reg(ssp_pkg::ADDR_BUF, rv);
    `CHK(rv, 8'h69)
  endtask
  task t_slave;
    int k;
    logic [7:0] pat;
    pat = 8'hC3;
    wr_reg(ssp_pkg::ADDR_CTL, 8'h00);
    wr_reg(ssp_pkg::ADDR_STAT, 8'h40);
    wr_reg(ssp_pkg::ADDR_CTL, 8'h24);
    repeat (4) @(posedge mclk);
    `CHK(sdo_oe, 1'b0)
    k = irq_cnt;
    sleep <= 1'b1;
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tb_sdi <= pat[i];
      repeat (8) @(posedge mclk); sck_in <= 1'b1;
      repeat (8) @(posedge mclk); sck_in <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    `CHK(sdo_oe, 1'b1)
    ss_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(sdo_oe, 1'b0)
    `CHK(irq_cnt, k + 1)
    `CHK(wake_cnt, 1)
    sleep <= 1'b0;
    rd_reg(ssp_pkg::ADDR_BUF, rv);
    `CHK(rv, 8'hC3)
  endtask
  task t_abort;
    wr_reg(ssp_pkg::ADDR_CTL, 8'h00);
    wr_reg(ssp_pkg::ADDR_CTL, 8'h22);
    start_byte(8'h00, 8'h11);
    repeat (5) @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk); rst <= 1'b0;
    t_reset();
  endtask
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 2'h0; wdata = 8'h00;
    sleep = 1'b0; sck_in = 1'b0; tb_sdi = 1'b0; ss_n = 1'b1;
    load = 1'b0; tx_byte = 8'h00; tmr_tick = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset(); t_master(); t_collide(); t_rates();
    t_sleep(); t_slave(); t_abort();
    end_of_test();
  end
endmodule
